// ==== design/serializer_pkg.sv ====
// constants and carrier types of the seven-to-one serializer
//
// Behaviour
// - capture all 21 inputs each word-clock rise while not shut down
// - word split into three seven-bit shift registers
// - bit clock seven times word clock shifts slices
// - three data lanes plus forwarded clock out
// - forwarded clock runs at word clock rate
// - shutdown low stops clock, disables line drivers
// - shutdown low clears the registers past the synchronisers, all but the word clock level
// - slice bit n starts 6-n sevenths after clock rise
// - forwarded clock high four, low three bits
// - lanes valid only after lock time elapses
// - shutdown reaches off state, clock low, quickly
package serializer_pkg;

    // ----------------------------------------
    // word layout
    // ----------------------------------------
    localparam int WORD_BITS = 21;
    localparam int LANES = 3;
    localparam int SLICE_BITS = 7;
    localparam logic [2:0] SLICE_LAST = 3'h6;
    localparam logic [2:0] FCLK_HIGH_BITS = 3'h4;
    localparam int FIFO_DEPTH = 32;
    localparam int SYNC_STAGES = 3;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CORE_CLK_MHZ = 50;
    localparam int LOCK_TIME_MS = 1;
    localparam int LOCK_CYCLES = LOCK_TIME_MS * 1000 * CORE_CLK_MHZ;
    localparam int LOCK_CNT_BITS = 17;
    localparam int DISABLE_TIME_NS = 250;
    localparam int DISABLE_CYCLES = (DISABLE_TIME_NS * CORE_CLK_MHZ) / 1000;
    localparam int WORD_CLK_MIN_MHZ = 20;
    localparam int WORD_CLK_MAX_MHZ = 65;

    // ----------------------------------------
    // carrier types
    // ----------------------------------------
    typedef struct packed {
        logic [LANES-1:0][SLICE_BITS-1:0] lane;
    } word_s;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] clk_sync;
        logic [SYNC_STAGES-1:0] pdn_sync;
        word_s data_s1;
        word_s data_s2;
        word_s data_s3;
        logic clk_level;
        logic on;
        logic locked;
        logic [LOCK_CNT_BITS-1:0] lock_cnt;
        word_s hold;
        logic hold_valid;
        word_s xfer;
        logic req;
        logic [1:0] ack_sync;
    } core_state_s;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] req_sync;
        logic [1:0] lock_sync;
        logic [2:0] cnt;
        word_s pend;
        logic pend_valid;
        word_s sreg;
        logic fclk;
        logic oe;
        logic ack;
    } link_state_s;

endpackage

// ==== design/word_fifo.sv ====
// synchronous word buffer with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } fifo_state_s;

    fifo_state_s st_reg;
    fifo_state_s st_next;
    logic push;
    logic pop;

    // honest flags from the occupancy count
    assign in_ready = st_reg.count != (AW+1)'(DEPTH);
    assign out_valid = st_reg.count != '0;
    assign out_data = st_reg.mem[st_reg.rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // next state: write, read, count
    always_comb begin
        st_next = st_reg;
        if (clear) begin
            st_next.wptr = '0;
            st_next.rptr = '0;
            st_next.count = '0;
            st_next.mem = '0;
        end else begin
            if (push) begin
                st_next.mem[st_reg.wptr] = in_data;
                st_next.wptr = st_reg.wptr + 1'b1;
            end
            if (pop) begin
                st_next.rptr = st_reg.rptr + 1'b1;
            end
            if (push && !pop) begin
                st_next.count = st_reg.count + 1'b1;
            end else if (pop && !push) begin
                st_next.count = st_reg.count - 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // occupancy bookkeeping checks
    chk_fifo_full_block: assert property (@(posedge clk) disable iff (rst)
        (st_reg.count == (AW+1)'(DEPTH)) |-> !in_ready)
        else $error("fifo accepts data while full");
    chk_fifo_count_step: assert property (@(posedge clk) disable iff (rst)
        (push && !pop && !clear) |=> st_reg.count == $past(st_reg.count) + 1'b1)
        else $error("fifo count did not rise on push");
endmodule

// ==== design/lvds_7to1_serializer_tx.sv ====
// seven-to-one serializer: word capture, buffering, lane shifting
`timescale 1ns/1ps
module lvds_7to1_serializer_tx #(
    parameter int LOCK_CYCLES = serializer_pkg::LOCK_CYCLES,
    parameter int FIFO_DEPTH = serializer_pkg::FIFO_DEPTH
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // parallel source side
    input wire logic parallel_word_clock,
    input wire logic [serializer_pkg::WORD_BITS-1:0] parallel_data_in,
    input wire logic power_down_clear_n,
    output logic capture_ready,
    // link side, seven-times bit clock
    input wire logic serial_bit_clk,
    output logic [serializer_pkg::LANES-1:0] serial_lane_outputs,
    output logic forwarded_link_clock,
    output logic line_driver_enable
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    serializer_pkg::core_state_s core_reg;
    serializer_pkg::core_state_s core_next;
    serializer_pkg::link_state_s link_reg;
    serializer_pkg::link_state_s link_next;
    logic pdn_high;
    logic pdn_low;
    logic clk_high;
    logic clk_low;
    logic word_rise;
    logic busy;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [serializer_pkg::WORD_BITS-1:0] fifo_out_data;
    logic req_edge;

    // ----------------------------------------
    // core domain: pin synchronisers
    // ----------------------------------------

    // a change counts once the second and third stages agree
    assign pdn_high = core_reg.pdn_sync[1] && core_reg.pdn_sync[2];
    assign pdn_low = !core_reg.pdn_sync[1] && !core_reg.pdn_sync[2];
    assign clk_high = core_reg.clk_sync[1] && core_reg.clk_sync[2];
    assign clk_low = !core_reg.clk_sync[1] && !core_reg.clk_sync[2];
    assign word_rise = clk_high && !core_reg.clk_level && core_reg.on;

    // word handed over while request and acknowledge differ
    assign busy = core_reg.req != core_reg.ack_sync[1];
    assign fifo_pop = fifo_out_valid && core_reg.locked && !busy;
    assign capture_ready = fifo_in_ready;

    // ----------------------------------------
    // core domain: buffer between capture and link
    // ----------------------------------------
    word_fifo #(
        .WIDTH(serializer_pkg::WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_word_fifo (
        .clk(core_clk),
        .rst(rst),
        .clear(pdn_low),
        .in_valid(core_reg.hold_valid),
        .in_ready(fifo_in_ready),
        .in_data(core_reg.hold),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------
    // core domain: capture, lock timer, hand-over
    // ----------------------------------------

    // next state of the core side
    always_comb begin
        core_next = core_reg;
        core_next.clk_sync = {core_reg.clk_sync[1:0], parallel_word_clock};
        core_next.pdn_sync = {core_reg.pdn_sync[1:0], power_down_clear_n};
        core_next.data_s1 = parallel_data_in;
        core_next.data_s2 = core_reg.data_s1;
        core_next.data_s3 = core_reg.data_s2;
        if (clk_high) begin
            core_next.clk_level = 1'b1;
        end else if (clk_low) begin
            core_next.clk_level = 1'b0;
        end
        if (pdn_low) begin
            // shutdown clears everything past the synchronisers except the word clock level
            core_next.on = 1'b0;
            core_next.locked = 1'b0;
            core_next.lock_cnt = '0;
            core_next.hold = '0;
            core_next.hold_valid = 1'b0;
            core_next.xfer = '0;
            core_next.req = 1'b0;
            core_next.ack_sync = '0;
        end else begin
            if (pdn_high) begin
                core_next.on = 1'b1;
            end
            core_next.ack_sync = {core_reg.ack_sync[0], link_reg.ack};
            // lanes held off until the lock time has run
            if (core_reg.on && !core_reg.locked) begin
                if (core_reg.lock_cnt == LOCK_CYCLES[serializer_pkg::LOCK_CNT_BITS-1:0] - 1'b1) begin
                    core_next.locked = 1'b1;
                end else begin
                    core_next.lock_cnt = core_reg.lock_cnt + 1'b1;
                end
            end
            // every rise of the word clock while the core flag is on and shutdown is not low takes all inputs
            if (word_rise) begin
                core_next.hold = core_reg.data_s3;
                core_next.hold_valid = 1'b1;
            end else if (core_reg.hold_valid && fifo_in_ready) begin
                core_next.hold_valid = 1'b0;
            end
            // one word at a time towards the link
            if (fifo_pop) begin
                core_next.xfer = fifo_out_data;
                core_next.req = !core_reg.req;
            end
        end
    end

    // core state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            core_reg <= '0;
        end else begin
            core_reg <= core_next;
        end
    end

    // ----------------------------------------
    // link domain: slice counter and shift registers
    // ----------------------------------------

    // toggle edge seen where the two late stages differ
    assign req_edge = link_reg.req_sync[1] != link_reg.req_sync[2];

    // next state of the link side
    always_comb begin
        link_next = link_reg;
        link_next.req_sync = {link_reg.req_sync[1:0], core_reg.req};
        link_next.lock_sync = {link_reg.lock_sync[0], core_reg.locked};
        if (!link_reg.lock_sync[1]) begin
            // forwarded clock held low and registers cleared while unlocked
            link_next.cnt = '0;
            link_next.pend = '0;
            link_next.pend_valid = 1'b0;
            link_next.sreg = '0;
            link_next.fclk = 1'b0;
            link_next.oe = 1'b0;
            link_next.ack = 1'b0;
        end else begin
            link_next.oe = 1'b1;
            if (req_edge) begin
                link_next.pend = core_reg.xfer;
                link_next.pend_valid = 1'b1;
            end
            if (link_reg.cnt == serializer_pkg::SLICE_LAST) begin
                // parallel load of all three slices at the period boundary
                link_next.cnt = '0;
                link_next.sreg = link_reg.pend_valid ? link_reg.pend : '0;
                if (link_reg.pend_valid) begin
                    link_next.pend_valid = 1'b0;
                    link_next.ack = !link_reg.ack;
                end
            end else begin
                // one bit per bit clock, highest slice bit first
                link_next.cnt = link_reg.cnt + 1'b1;
                for (int k = 0; k < serializer_pkg::LANES; k++) begin
                    link_next.sreg.lane[k] = {link_reg.sreg.lane[k][serializer_pkg::SLICE_BITS-2:0],
                        1'b0};
                end
            end
            // clock high for the first four bit times
            link_next.fclk = link_next.cnt < serializer_pkg::FCLK_HIGH_BITS;
        end
    end

    // link state register
    always_ff @(posedge serial_bit_clk or posedge rst) begin
        if (rst) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    // ----------------------------------------
    // line outputs
    // ----------------------------------------

    // three data lanes, each gated off at shutdown
    for (genvar k = 0; k < serializer_pkg::LANES; k++) begin : g_lane
        assign serial_lane_outputs[k] =
            link_reg.sreg.lane[k][serializer_pkg::SLICE_BITS-1] && core_reg.on;
    end

    // forwarded clock and driver enable drop with the core flag
    assign forwarded_link_clock = link_reg.fclk && core_reg.on;
    assign line_driver_enable = link_reg.oe && core_reg.on;

    // ----------------------------------------
    // checks
    // ----------------------------------------

    chk_capture_holds_word: assert property (@(posedge core_clk) disable iff (rst)
        (word_rise && !pdn_low) |=> core_reg.hold == $past(core_reg.data_s3))
        else $error("captured word differs from inputs");

    chk_shutdown_clears: assert property (@(posedge core_clk) disable iff (rst)
        pdn_low |=> (core_reg.hold == '0 && !core_reg.locked && core_reg.lock_cnt == '0))
        else $error("shutdown left core registers set");

    chk_shutdown_off_time: assert property (@(posedge core_clk) disable iff (rst)
        pdn_low |-> ##[1:12] (!forwarded_link_clock && !line_driver_enable))
        else $error("outputs not off within disable time");

    chk_lock_wait_length: assert property (@(posedge core_clk) disable iff (rst)
        $rose(core_reg.locked) |-> $past(core_reg.lock_cnt) ==
            LOCK_CYCLES[serializer_pkg::LOCK_CNT_BITS-1:0] - 1'b1)
        else $error("lock flag rose before lock time");

    chk_slice_count: assert property (@(posedge serial_bit_clk) disable iff (rst)
        (link_reg.oe && link_reg.lock_sync[1] && link_reg.cnt != serializer_pkg::SLICE_LAST)
            |=> link_reg.cnt == $past(link_reg.cnt) + 1'b1 || !link_reg.oe)
        else $error("slice counter skipped a bit time");

    chk_fclk_shape: assert property (@(posedge serial_bit_clk) disable iff (rst)
        (link_reg.oe && link_reg.cnt == 3'h0)
            |-> (link_reg.fclk || !link_reg.oe) [*4] ##1 !link_reg.fclk [*3])
        else $error("forwarded clock not four high three low");

    chk_slice_load: assert property (@(posedge serial_bit_clk) disable iff (rst)
        (link_reg.lock_sync[1] && link_reg.cnt == serializer_pkg::SLICE_LAST
            && link_reg.pend_valid) |=> link_reg.sreg == $past(link_reg.pend))
        else $error("pending word not loaded at period boundary");

    chk_bit_order: assert property (@(posedge serial_bit_clk) disable iff (rst)
        (link_reg.oe && link_reg.cnt == 3'h0) |-> ##6
            (link_reg.sreg.lane[0][6] == $past(link_reg.sreg.lane[0][0], 6) || !link_reg.oe))
        else $error("lowest input not in last bit position");

    chk_ack_on_load: assert property (@(posedge serial_bit_clk) disable iff (rst)
        (link_reg.lock_sync[1] && $changed(link_reg.ack))
            |-> $past(link_reg.cnt) == serializer_pkg::SLICE_LAST)
        else $error("acknowledge toggled away from slice load");

    // ----------------------------------------
    // checks: gating, hand-over, shifting
    // ----------------------------------------

    // lanes forced low whenever the core flag is off
    chk_lanes_gated_off: assert property (@(posedge core_clk) disable iff (rst)
        !core_reg.on |-> (serial_lane_outputs == '0 && !line_driver_enable))
        else $error("lanes driven while shut down");

    // forwarded clock held low in the off state
    chk_fclk_low_off: assert property (@(posedge core_clk) disable iff (rst)
        !core_reg.on |-> !forwarded_link_clock)
        else $error("forwarded clock high while shut down");

    // held word leaves for the buffer once it has room
    chk_hold_pushed: assert property (@(posedge core_clk) disable iff (rst)
        (core_reg.hold_valid && fifo_in_ready && !pdn_low && !word_rise)
            |=> !core_reg.hold_valid)
        else $error("held word not pushed into buffer");

    // word under hand-over stays put until acknowledged
    chk_xfer_stable: assert property (@(posedge core_clk) disable iff (rst)
        (busy && !pdn_low) |=> core_reg.xfer == $past(core_reg.xfer))
        else $error("hand-over word changed before acknowledge");

    // line drivers stay off while the lock flag is low
    chk_driver_off_unlocked: assert property (@(posedge serial_bit_clk) disable iff (rst)
        !link_reg.lock_sync[1] |=> !link_reg.oe)
        else $error("line driver enabled before lock");

    // idle boundary loads an all-zero slice
    chk_idle_slice_zero: assert property (@(posedge serial_bit_clk) disable iff (rst)
        (link_reg.lock_sync[1] && link_reg.cnt == serializer_pkg::SLICE_LAST
            && !link_reg.pend_valid) |=> link_reg.sreg == '0)
        else $error("idle period did not send zeros");

    // each bit clock but the boundary moves lane 0 one place up
    chk_shift_step: assert property (@(posedge serial_bit_clk) disable iff (rst)
        (link_reg.lock_sync[1] && link_reg.cnt != serializer_pkg::SLICE_LAST)
            |=> link_reg.sreg.lane[0][6:1] == $past(link_reg.sreg.lane[0][5:0]))
        else $error("lane shift register did not step");
endmodule

// ==== verif/link_receiver_model.sv ====
// behavioural deserializing receiver at the far side of the link
`timescale 1ns/1ps
module link_receiver_model (
    // link clock and reset
    input wire logic serial_bit_clk,
    input wire logic rst,
    // serial side
    input wire logic [serializer_pkg::LANES-1:0] serial_lane_outputs,
    input wire logic forwarded_link_clock,
    input wire logic line_driver_enable,
    // recovered frames
    output serializer_pkg::word_s rx_word,
    output logic [3:0] rx_len,
    output logic [3:0] rx_high,
    output logic rx_stb
);
    serializer_pkg::word_s acc;
    logic prev_fclk;
    logic prev_en;
    logic started;
    logic [3:0] cnt;
    logic [3:0] hcnt;
    int k;

    // ----------------------------------------
    // frame recovery
    // ----------------------------------------
    // sample mid-bit; a frame is emitted at the next clock rise
    always @(negedge serial_bit_clk or posedge rst) begin
        if (rst) begin
            started <= 1'b0;
            prev_fclk <= 1'b0;
            prev_en <= 1'b0;
            rx_stb <= 1'b0;
            rx_word <= '0;
            rx_len <= 4'h0;
            rx_high <= 4'h0;
            cnt <= 4'h0;
            hcnt <= 4'h0;
            acc <= '0;
        end else begin
            rx_stb <= 1'b0;
            prev_fclk <= forwarded_link_clock;
            prev_en <= line_driver_enable;
            // a clock rise seen together with the enable rise is no frame start
            if (!line_driver_enable) begin // ignore lanes until valid
                started <= 1'b0;
            end else if (forwarded_link_clock && !prev_fclk && prev_en) begin
                if (started) begin
                    rx_word <= acc;
                    rx_len <= cnt;
                    rx_high <= hcnt;
                    rx_stb <= 1'b1;
                end
                started <= 1'b1;
                cnt <= 4'h1;
                hcnt <= 4'h1;
                for (k = 0; k < 3; k++) begin // position 0 at clock rise
                    acc.lane[k] <= {6'h0, serial_lane_outputs[k]};
                end
            end else begin
                cnt <= cnt + 4'h1;
                hcnt <= hcnt + {3'h0, forwarded_link_clock};
                for (k = 0; k < 3; k++) begin // lowest input arrives last
                    acc.lane[k] <= {acc.lane[k][5:0], serial_lane_outputs[k]};
                end
            end
        end
    end
endmodule

// ==== verif/lvds_7to1_serializer_tx_tb_top.sv ====
// self-checking bench of the seven-to-one serializer
`timescale 1ns/1ps
module lvds_7to1_serializer_tx_tb_top;
    logic core_clk = 1'b0;
    logic serial_bit_clk = 1'b0;
    logic rst = 1'b1;
    logic word_clk = 1'b0;
    logic [20:0] data_in = 21'h00_0000;
    logic pdn_n = 1'b1;
    logic capture_ready;
    logic [2:0] lanes;
    logic fclk;
    logic drv_en;
    serializer_pkg::word_s rx_word;
    logic [3:0] rx_len;
    logic [3:0] rx_high;
    logic rx_stb;
    logic [20:0] exp_q[$];
    logic [31:0] lfsr_reg = 32'h0000_0037;
    logic full_seen = 1'b0;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;
    int i;
    int k;

    // ----------------------------------------
    // clocks, instances
    // ----------------------------------------
    always #10 core_clk = ~core_clk;
    initial begin
        #13;
        forever #80 serial_bit_clk = ~serial_bit_clk;
    end

    lvds_7to1_serializer_tx #(.LOCK_CYCLES(20), .FIFO_DEPTH(32)) lvds_7to1_serializer_tx_i (
        .core_clk(core_clk), .rst(rst), .parallel_word_clock(word_clk),
        .parallel_data_in(data_in), .power_down_clear_n(pdn_n),
        .capture_ready(capture_ready), .serial_bit_clk(serial_bit_clk),
        .serial_lane_outputs(lanes), .forwarded_link_clock(fclk),
        .line_driver_enable(drv_en));

    link_receiver_model link_receiver_model_i (
        .serial_bit_clk(serial_bit_clk), .rst(rst), .serial_lane_outputs(lanes),
        .forwarded_link_clock(fclk), .line_driver_enable(drv_en), .rx_word(rx_word),
        .rx_len(rx_len), .rx_high(rx_high), .rx_stb(rx_stb));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [20:0] rand_word();
        lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
        return (lfsr_reg[20:0] == 21'h00_0000) ? 21'h00_0001 : lfsr_reg[20:0];
    endfunction

    // one word clock period, waiting while the buffer is full
    task automatic send_word(input logic [20:0] w, input bit expect_it);
        k = 0;
        while (capture_ready !== 1'b1 && k < 3000) begin
            @(negedge core_clk);
            k++;
        end
        @(posedge core_clk);
        data_in <= w;
        repeat (3) @(posedge core_clk);
        // slow word clock: both levels last several core cycles
        word_clk <= 1'b1;
        if (expect_it) exp_q.push_back(w);
        repeat (4) @(posedge core_clk);
        word_clk <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wait_enable();
        repeat (15) @(negedge core_clk);
        chk("enable before lock", 21'h0, {20'h0, drv_en});
        k = 0;
        while (drv_en !== 1'b1 && k < 400) begin
            @(negedge core_clk);
            k++;
        end
        chk("enable after lock", 21'h1, {20'h0, drv_en});
    endtask

    task automatic drain();
        k = 0;
        while (exp_q.size() != 0 && k < 30000) begin
            @(negedge core_clk);
            k++;
        end
        chk("words left", 21'h0, 21'(exp_q.size()));
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // frame checker and watchdog
    // ----------------------------------------
    always @(posedge serial_bit_clk) begin
        if (rx_stb === 1'b1) begin
            chk("clock period bits", 21'h7, {17'h0, rx_len});
            chk("clock high bits", 21'h4, {17'h0, rx_high});
            if (rx_word !== 21'h00_0000) begin
                if (exp_q.size() == 0) begin
                    chk("stray word", 21'h0, rx_word);
                end else begin
                    chk("received word", exp_q.pop_front(), rx_word);
                end
            end
        end
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (capture_ready === 1'b0) full_seen <= 1'b1;
        if (cycles == 80000) begin
            n_fail++;
            $display("unexpected run length: expected 80000 seen more");
            end_sim();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        wait_enable();
        // corner words then random traffic
        send_word(21'h1f_ffff, 1'b1);
        send_word(21'h00_0001, 1'b1);
        send_word(21'h10_0000, 1'b1);
        send_word(21'h15_5555, 1'b1);
        send_word(21'h00_0080, 1'b1);
        for (i = 0; i < 12; i++) send_word(rand_word(), 1'b1);
        drain();
        // burst of 45 words that overfills the buffer, waiting while it refuses, then drain it
        for (i = 0; i < 45; i++) send_word(rand_word(), 1'b1);
        chk("buffer filled", 21'h1, {20'h0, full_seen});
        drain();
        chk("buffer empty", 21'h1, {20'h0, capture_ready});
        // shutdown in mid traffic
        for (i = 0; i < 3; i++) send_word(rand_word(), 1'b1);
        @(posedge core_clk);
        pdn_n <= 1'b0;
        repeat (12) @(negedge core_clk);
        for (i = 0; i < 40; i++) begin
            chk("off outputs", 21'h0, {16'h0, drv_en, fclk, lanes});
            @(negedge core_clk);
        end
        exp_q.delete();
        send_word(21'h0a_5a5a, 1'b0);
        @(posedge core_clk);
        pdn_n <= 1'b1;
        wait_enable();
        repeat (600) @(negedge core_clk);
        send_word(21'h12_3456, 1'b1);
        drain();
        end_sim();
    end
endmodule
